/* File: src/prot_cfg.svh */
// Purpose: Constants for the protection fault supervisor
// Assumes: 50 MHz clock, APB byte addresses
// Notes: Counts are derived from times in microseconds
`ifndef PROT_CFG_SVH
`define PROT_CFG_SVH
`define CLK_MHZ          50
`define TW               24
// Register byte offsets
`define ADDR_CTRL        8'h00
`define ADDR_LEVELS      8'h04
`define ADDR_OCP1_LIM    8'h08
`define ADDR_OCP2_LIM    8'h0C
`define ADDR_MAX_LIM     8'h10
`define ADDR_WINDOW      8'h14
`define ADDR_TIMEOUT     8'h18
`define ADDR_SBO_BLANK   8'h1C
`define ADDR_SAMPLE      8'h20
`define ADDR_ARM_STEPS   8'h24
`define ADDR_PULSE_NUM   8'h28
`define ADDR_STATUS      8'h2C
// Field positions
`define LVL1_LSB         0
`define LVL2_LSB         8
`define LVMX_LSB         16
`define CTRL_EN          0
`define STAT_STATE_LSB   16
// Times in microseconds and reset values
`define SAMPLE_US        10
`define WINDOW_US        50000
`define TIMEOUT_US       100000
`define SBO_BLANK_US     50000
`define OCP1_US          100000
`define OCP2_US          20000
`define MAX_US           10000
`define ARM_BASE_US      1000
`define RST_CTRL         32'h0000_0001
`define RST_LEVELS       32'h00E0_D0C0
`define RST_ARM_STEPS    8'h0A
`define RST_PULSE_NUM    32'h0010_0000
`define ZERO32           32'h0000_0000
`endif

/* File: src/prot_pkg.sv */
// Purpose: Types shared by the protection fault supervisor
// Assumes: prot_cfg.svh supplies the numbers
// Notes: Structs carry related signals as one port
package prot_pkg;
  typedef struct packed {
    logic hs_above_on;
    logic hs_below_off;
    logic brown_in;
    logic slow_low;
    logic fast_low;
    logic overvolt;
  } cmp_t;
  typedef struct packed {
    logic switch_pulse;
    logic hs_on;
    logic burst_wakeup;
  } ctl_t;
  typedef struct packed {
    logic hs_driver_en;
    logic ls_gate_en;
    logic hs_gate_en;
    logic bang_bang;
    logic auto_restart;
    logic burst_frame_start;
    logic startup_request;
  } gate_t;
  typedef struct packed {
    logic window;
    logic fast_bo;
    logic slow_bo;
    logic overvolt;
    logic timeout;
    logic shunt;
    logic ocp1;
    logic ocp2;
    logic ocp_max;
  } fault_t;
  typedef enum logic [2:0] {ST_CHECK, ST_RUN, ST_BANG, ST_SLEEP} state_t;
endpackage

/* File: src/protection_fault_supervisor.sv */
// Purpose: Protection supervisor for the half-bridge flyback controller
// Assumes: Comparator inputs are asynchronous, controller inputs on clk
// Notes: Registers on APB, no wait state per transfer
`timescale 1ns/100ps
`include "prot_cfg.svh"
module protection_fault_supervisor #(
  parameter int ARM_BASE_CYCLES = `ARM_BASE_US * `CLK_MHZ,
  parameter int SW = 8,
  parameter int VW = 12
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire prot_pkg::cmp_t       cmp,
  input  wire prot_pkg::ctl_t       ctl,
  input  wire logic [SW-1:0]        iset,
  input  wire logic [SW-1:0]        iset_startup,
  input  wire logic [VW-1:0]        vs_sample,
  output prot_pkg::gate_t           gate,
  output logic      [SW-1:0]        iset_clamped
);
  localparam int TW = `TW;
  localparam int NC = $bits(prot_pkg::cmp_t);

  prot_pkg::state_t      state_r;
  prot_pkg::state_t      state_nxt;
  prot_pkg::gate_t       gate_r;
  prot_pkg::fault_t      fault_now;
  prot_pkg::fault_t      sticky_r;
  prot_pkg::cmp_t        cs;
  logic [NC-1:0]         s1_r;
  logic [NC-1:0]         s2_r;
  logic [NC-1:0]         s3_r;
  logic [NC-1:0]         st_r;
  logic [31:0]           ctrl_r;
  logic [31:0]           levels_r;
  logic [TW-1:0]         lim_r [3];
  logic [TW-1:0]         window_r;
  logic [TW-1:0]         timeout_r;
  logic [TW-1:0]         sbo_blank_r;
  logic [TW-1:0]         sample_r;
  logic [7:0]            arm_steps_r;
  logic [31:0]           pulse_num_r;
  logic [31:0]           prdata_r;
  logic                  pready_r;
  logic                  pslverr_r;
  logic [SW-1:0]         iset_r;
  logic [TW-1:0]         smp_cnt_r;
  logic                  tick_r;
  logic [TW-1:0]         win_cnt_r;
  logic [TW-1:0]         sbo_cnt_r;
  logic [TW-1:0]         st_cnt_r;
  logic                  startup_r;
  logic                  first_seen_r;
  logic                  first_on_r;
  logic [31:0]           on_cnt_r;
  logic [31:0]           max_on_r;
  logic [TW-1:0]         ocp_cnt_r [3];
  logic [2:0]            ocp_hit;
  logic [2:0]            ocp_over;
  logic [TW-1:0]         base_cnt_r;
  logic [7:0]            step_cnt_r;
  logic                  in_range;
  logic                  wr_en;
  logic [SW-1:0]         lvl_max;

  assign cs        = prot_pkg::cmp_t'(st_r);
  assign in_range  = cs.brown_in && !cs.overvolt;
  assign wr_en     = psel && penable && pready_r && pwrite;
  assign lvl_max   = levels_r[`LVMX_LSB +: SW];
  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign gate      = gate_r;
  assign iset_clamped = iset_r;

  // Three-stage synchroniser, change accepted when stages two and three agree
  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : g_sync
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
          s3_r[g] <= 1'b0;
          st_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= cmp[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (s2_r[g] == s3_r[g]) begin
            st_r[g] <= s3_r[g];
          end
        end
      end
    end
  endgenerate

  // APB slave, answer in first access cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_r  <= `ZERO32;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (psel && !penable) begin
      pready_r  <= 1'b1;
      pslverr_r <= 1'b0;
      unique case (paddr)
        `ADDR_CTRL:      prdata_r <= ctrl_r;
        `ADDR_LEVELS:    prdata_r <= levels_r;
        `ADDR_OCP1_LIM:  prdata_r <= 32'(lim_r[0]);
        `ADDR_OCP2_LIM:  prdata_r <= 32'(lim_r[1]);
        `ADDR_MAX_LIM:   prdata_r <= 32'(lim_r[2]);
        `ADDR_WINDOW:    prdata_r <= 32'(window_r);
        `ADDR_TIMEOUT:   prdata_r <= 32'(timeout_r);
        `ADDR_SBO_BLANK: prdata_r <= 32'(sbo_blank_r);
        `ADDR_SAMPLE:    prdata_r <= 32'(sample_r);
        `ADDR_ARM_STEPS: prdata_r <= 32'(arm_steps_r);
        `ADDR_PULSE_NUM: prdata_r <= pulse_num_r;
        `ADDR_STATUS:    prdata_r <= 32'({state_r, 7'(0), sticky_r});
        default: begin
          prdata_r  <= `ZERO32;
          pslverr_r <= 1'b1;
        end
      endcase
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r      <= `RST_CTRL;
      levels_r    <= `RST_LEVELS;
      lim_r[0]    <= TW'(`OCP1_US * `CLK_MHZ);
      lim_r[1]    <= TW'(`OCP2_US * `CLK_MHZ);
      lim_r[2]    <= TW'(`MAX_US * `CLK_MHZ);
      window_r    <= TW'(`WINDOW_US * `CLK_MHZ);
      timeout_r   <= TW'(`TIMEOUT_US * `CLK_MHZ);
      sbo_blank_r <= TW'(`SBO_BLANK_US * `CLK_MHZ);
      sample_r    <= TW'(`SAMPLE_US * `CLK_MHZ);
      arm_steps_r <= `RST_ARM_STEPS;
      pulse_num_r <= `RST_PULSE_NUM;
    end else if (wr_en) begin
      unique case (paddr)
        `ADDR_CTRL:      ctrl_r      <= pwdata;
        `ADDR_LEVELS:    levels_r    <= pwdata;
        `ADDR_OCP1_LIM:  lim_r[0]    <= pwdata[TW-1:0];
        `ADDR_OCP2_LIM:  lim_r[1]    <= pwdata[TW-1:0];
        `ADDR_MAX_LIM:   lim_r[2]    <= pwdata[TW-1:0];
        `ADDR_WINDOW:    window_r    <= pwdata[TW-1:0];
        `ADDR_TIMEOUT:   timeout_r   <= pwdata[TW-1:0];
        `ADDR_SBO_BLANK: sbo_blank_r <= pwdata[TW-1:0];
        `ADDR_SAMPLE:    sample_r    <= pwdata[TW-1:0];
        `ADDR_ARM_STEPS: arm_steps_r <= pwdata[7:0];
        `ADDR_PULSE_NUM: pulse_num_r <= pwdata;
        default: ;
      endcase
    end
  end

  // Sticky fault causes; a new fault wins over a write-one clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sticky_r <= '0;
    end else if (wr_en && paddr == `ADDR_STATUS) begin
      sticky_r <= (sticky_r & ~pwdata[$bits(prot_pkg::fault_t)-1:0])
                  | fault_now;
    end else begin
      sticky_r <= sticky_r | fault_now;
    end
  end

  // Sample period enable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      smp_cnt_r <= '0;
      tick_r    <= 1'b0;
    end else if (smp_cnt_r + TW'(1) >= sample_r) begin
      smp_cnt_r <= '0;
      tick_r    <= 1'b1;
    end else begin
      smp_cnt_r <= smp_cnt_r + TW'(1);
      tick_r    <= 1'b0;
    end
  end

  // Slow dropout blanking counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sbo_cnt_r <= '0;
    end else if (!cs.slow_low || state_r != prot_pkg::ST_RUN) begin
      sbo_cnt_r <= '0;
    end else if (sbo_cnt_r < sbo_blank_r) begin
      sbo_cnt_r <= sbo_cnt_r + TW'(1);
    end
  end

  // Start-up check window
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      win_cnt_r <= '0;
    end else if (state_r != prot_pkg::ST_CHECK || !ctrl_r[`CTRL_EN]) begin
      win_cnt_r <= '0;
    end else if (win_cnt_r < window_r) begin
      win_cnt_r <= win_cnt_r + TW'(1);
    end
  end

  // Start-up duration and first pulse supervision
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      startup_r    <= 1'b0;
      first_seen_r <= 1'b0;
      first_on_r   <= 1'b0;
      st_cnt_r     <= '0;
      on_cnt_r     <= '0;
      max_on_r     <= '0;
    end else if (state_r != prot_pkg::ST_RUN) begin
      startup_r    <= 1'b0;
      first_seen_r <= 1'b0;
      first_on_r   <= 1'b0;
      st_cnt_r     <= '0;
      on_cnt_r     <= '0;
    end else begin
      if (gate_r.startup_request) begin
        startup_r <= 1'b1;
      end
      if (startup_r && ctl.switch_pulse && !first_seen_r) begin
        first_seen_r <= 1'b1;
        first_on_r   <= 1'b1;
        // Zero input reading gives the longest limit, not a divide fault
        max_on_r     <= (vs_sample == '0) ? '1 :
                        pulse_num_r / 32'(vs_sample);
      end
      if (first_seen_r && startup_r) begin
        st_cnt_r <= st_cnt_r + TW'(1);
        if (iset < iset_startup) begin
          startup_r <= 1'b0;
        end
      end
      if (first_on_r) begin
        if (ctl.hs_on) begin
          on_cnt_r <= on_cnt_r + 32'd1;
        end else if (on_cnt_r != '0) begin
          first_on_r <= 1'b0;
        end
      end
    end
  end

  // Overcurrent timers: level one, level two, ceiling
  assign ocp_over[0] = iset > levels_r[`LVL1_LSB +: SW];
  assign ocp_over[1] = iset > levels_r[`LVL2_LSB +: SW];
  assign ocp_over[2] = iset > lvl_max;
  generate
    for (g = 0; g < 3; g++) begin : g_ocp
      assign ocp_hit[g] = ocp_cnt_r[g] >= lim_r[g];
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          ocp_cnt_r[g] <= '0;
        end else if (!ocp_over[g] || state_r != prot_pkg::ST_RUN) begin
          ocp_cnt_r[g] <= '0;
        end else if (!ocp_hit[g]) begin
          ocp_cnt_r[g] <= ocp_cnt_r[g] + TW'(1);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      iset_r <= '0;
    end else begin
      iset_r <= ocp_over[2] ? lvl_max : iset;
    end
  end

  // Fault detection, window expiry in check, all others only while running
  always_comb begin
    fault_now = '0;
    if (state_r == prot_pkg::ST_CHECK) begin
      fault_now.window = ctrl_r[`CTRL_EN] && win_cnt_r >= window_r
                         && !in_range;
    end
    if (state_r == prot_pkg::ST_RUN) begin
      fault_now.fast_bo  = tick_r && cs.fast_low;
      fault_now.slow_bo  = sbo_cnt_r >= sbo_blank_r && cs.slow_low;
      fault_now.overvolt = tick_r && cs.overvolt;
      fault_now.timeout  = startup_r && st_cnt_r >= timeout_r;
      fault_now.shunt    = first_on_r && on_cnt_r > max_on_r;
      fault_now.ocp1     = ocp_hit[0] && ocp_over[0];
      fault_now.ocp2     = ocp_hit[1] && ocp_over[1];
      fault_now.ocp_max  = ocp_hit[2] && ocp_over[2];
    end
  end

  // Mode sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      prot_pkg::ST_CHECK: begin
        if (ctrl_r[`CTRL_EN] && in_range) begin
          state_nxt = prot_pkg::ST_RUN;
        end else if (fault_now.window) begin
          state_nxt = prot_pkg::ST_BANG;
        end
      end
      prot_pkg::ST_BANG: begin
        if (ctrl_r[`CTRL_EN] && in_range) begin
          state_nxt = prot_pkg::ST_RUN;
        end
      end
      prot_pkg::ST_RUN: begin
        // Auto-restart faults outrank dropout faults
        if (fault_now.overvolt || fault_now.timeout || fault_now.shunt
            || fault_now.ocp1 || fault_now.ocp2 || fault_now.ocp_max) begin
          state_nxt = prot_pkg::ST_SLEEP;
        end else if (fault_now.fast_bo || fault_now.slow_bo) begin
          state_nxt = prot_pkg::ST_BANG;
        end
      end
      prot_pkg::ST_SLEEP: begin
        if (step_cnt_r >= arm_steps_r) begin
          state_nxt = prot_pkg::ST_CHECK;
        end
      end
      default: state_nxt = prot_pkg::ST_CHECK;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= prot_pkg::ST_CHECK;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Auto-restart sleep timer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base_cnt_r <= '0;
      step_cnt_r <= '0;
    end else if (state_r != prot_pkg::ST_SLEEP) begin
      base_cnt_r <= '0;
      step_cnt_r <= '0;
    end else if (base_cnt_r + TW'(1) >= TW'(ARM_BASE_CYCLES)) begin
      base_cnt_r <= '0;
      step_cnt_r <= step_cnt_r + 8'd1;
    end else begin
      base_cnt_r <= base_cnt_r + TW'(1);
    end
  end

  // Gate and mode outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_r <= '0;
    end else begin
      if (cs.hs_below_off) begin
        gate_r.hs_driver_en <= 1'b0;
      end else if (cs.hs_above_on) begin
        gate_r.hs_driver_en <= 1'b1;
      end
      gate_r.ls_gate_en   <= state_nxt == prot_pkg::ST_RUN;
      gate_r.hs_gate_en   <= state_nxt == prot_pkg::ST_RUN
                             && !cs.hs_below_off;
      gate_r.bang_bang    <= state_nxt != prot_pkg::ST_RUN;
      gate_r.auto_restart <= state_nxt == prot_pkg::ST_SLEEP;
      gate_r.startup_request <= state_r != prot_pkg::ST_RUN
                                && state_nxt == prot_pkg::ST_RUN;
      gate_r.burst_frame_start <= state_r == prot_pkg::ST_RUN
                                  && ctl.burst_wakeup
                                  && !cs.overvolt;
    end
  end

  a_hs_drop_off: assert property (@(posedge clk) disable iff (!reset_n)
    cs.hs_below_off |=> !gate_r.hs_driver_en && !gate_r.hs_gate_en)
    else $error("high-side driver not cut on low supply");
  a_hs_on_hyst: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(gate_r.hs_driver_en) |-> $past(cs.hs_above_on && !cs.hs_below_off))
    else $error("high-side driver enabled without on level");
  a_prot_no_drive: assert property (@(posedge clk) disable iff (!reset_n)
    gate_r.bang_bang |-> !gate_r.ls_gate_en && !gate_r.hs_gate_en)
    else $error("gates driven in protection");
  a_ceiling_clamp: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 iset_r <= $past(lvl_max) || !$past(ocp_over[2]))
    else $error("set-point not clamped");
  a_ovp_restart: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == prot_pkg::ST_RUN && tick_r && cs.overvolt
    |=> state_r == prot_pkg::ST_SLEEP ##1 gate_r.auto_restart)
    else $error("overvoltage did not restart");
  a_fast_bang: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == prot_pkg::ST_RUN && tick_r && cs.fast_low && !cs.overvolt
    && !(|fault_now[5:0]) |=> state_r == prot_pkg::ST_BANG)
    else $error("fast dropout missed");
  a_window_bang: assert property (@(posedge clk) disable iff (!reset_n)
    fault_now.window |=> state_r == prot_pkg::ST_BANG)
    else $error("window expiry not bang-bang");
  a_burst_ovp: assert property (@(posedge clk) disable iff (!reset_n)
    gate_r.burst_frame_start |-> $past(!cs.overvolt && ctl.burst_wakeup))
    else $error("burst frame despite overvoltage");
  a_ocp1_clear: assert property (@(posedge clk) disable iff (!reset_n)
    !ocp_over[0] |=> ocp_cnt_r[0] == '0)
    else $error("level one timer not cleared");
  a_shunt_restart: assert property (@(posedge clk) disable iff (!reset_n)
    fault_now.shunt |=> state_r == prot_pkg::ST_SLEEP)
    else $error("long first pulse not restarted");
  a_sleep_exit: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == prot_pkg::ST_SLEEP && step_cnt_r < arm_steps_r
    |=> state_r == prot_pkg::ST_SLEEP)
    else $error("sleep ended early");
endmodule // protection_fault_supervisor

/* File: tb/front_model.sv */
// Purpose: Comparators and switching controller beside the supervisor
// Assumes: Analog levels arrive from the bench as plain counts
// Notes: PER sets pulse spacing, so the controller can be prompt or slow
`timescale 1ns/100ps
module front_model #(
  parameter int PER = 16
) (
  input  wire logic            clk,
  input  wire logic [11:0]     vin,
  input  wire logic [7:0]      hsv,
  input  wire logic            wake,
  input  wire prot_pkg::gate_t gate,
  output prot_pkg::cmp_t       cmp,
  output prot_pkg::ctl_t       ctl,
  output logic [11:0]          vs_sample
);
  int cnt = 0;
  // Hysteresis band lies between the two supply levels
  assign cmp.hs_above_on  = hsv > 8'h80;
  assign cmp.hs_below_off = hsv < 8'h40;
  // Fast level sits below slow, both below brown-in
  assign cmp.brown_in = vin > 12'h12C;
  assign cmp.slow_low = vin < 12'h0C8;
  assign cmp.fast_low = vin < 12'h064;
  assign cmp.overvolt = vin > 12'h384;
  // Pulses only while the supervisor lets the gates run
  always_ff @(posedge clk) begin
    cnt <= gate.ls_gate_en ? (cnt + 1) % PER : 0;
  end
  assign ctl.switch_pulse = gate.ls_gate_en && cnt == 1;
  assign ctl.hs_on = gate.hs_gate_en && cnt inside {[1:3]};
  assign ctl.burst_wakeup = wake;
  assign vs_sample = vin;
endmodule // front_model

/* File: tb/protection_fault_supervisor_bench.sv */
// Purpose: Self-checking bench for the protection supervisor
// Assumes: Short limits written over APB keep the run brief
// Notes: One task per scenario, each judges its own outcome
`timescale 1ns/100ps
`include "prot_cfg.svh"
module protection_fault_supervisor_bench;
  localparam int HSD = 6, LSG = 5, HSG = 4, BB = 3, AR = 2, BFS = 1, SRQ = 0;
  logic            clk = 0;
  logic            reset_n = 0;
  logic            psel = 0;
  logic            penable = 0;
  logic            pwrite = 0;
  logic [7:0]      paddr = 8'h00;
  logic [31:0]     pwdata = `ZERO32;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic [11:0]     vin = 12'h0FA;
  logic [7:0]      hsv = 8'h20;
  logic            wake = 0;
  logic [7:0]      iset = 8'h40;
  logic [7:0]      iset_st = 8'h80;
  logic [11:0]     vs_sample;
  logic [7:0]      iset_clamped;
  prot_pkg::cmp_t  cmp;
  prot_pkg::ctl_t  ctl;
  prot_pkg::gate_t gate;
  logic [6:0]      g;
  logic [31:0]     rd;
  logic            err;
  int              k;
  int              cycles = 0;
  int              miscompares = 0;
  int              checks_done = 0;
  assign g = gate;
  always #10 clk = ~clk;
  protection_fault_supervisor #(.ARM_BASE_CYCLES(10)) DUT (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp(cmp), .ctl(ctl),
    .iset(iset), .iset_startup(iset_st), .vs_sample(vs_sample),
    .gate(gate), .iset_clamped(iset_clamped));
  front_model #(.PER(16)) model (
    .clk(clk), .vin(vin), .hsv(hsv), .wake(wake), .gate(gate),
    .cmp(cmp), .ctl(ctl), .vs_sample(vs_sample));
  task automatic check(input string n, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Reads at the edge see pre-edge values, so no race with the slave
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic await(input int i, input logic v, input int lim,
                       input string n);
    k = 0;
    while (g[i] !== v && k < lim) begin
      @(posedge clk);
      k++;
    end
    check(n, g[i], v);
  endtask
  task automatic s_regs();
    check("bang after reset", g[BB], 1'b1);
    check("ls gate idle", g[LSG], 1'b0);
    apb(1'b0, `ADDR_CTRL, `ZERO32);
    check("ctrl reset", rd, `RST_CTRL);
    apb(1'b0, `ADDR_LEVELS, `ZERO32);
    check("levels reset", rd, `RST_LEVELS);
    apb(1'b0, 8'h30, `ZERO32);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, `ZERO32);
    apb(1'b1, `ADDR_SAMPLE, 32'h0000_0014);
    apb(1'b1, `ADDR_OCP1_LIM, 32'h0000_0028);
    apb(1'b1, `ADDR_SBO_BLANK, 32'h0000_001E);
    apb(1'b1, `ADDR_TIMEOUT, 32'h0000_003C);
    apb(1'b0, `ADDR_SAMPLE, `ZERO32);
    check("sample readback", rd, 32'h0000_0014);
  endtask
  task automatic s_hs();
    hsv <= 8'h60;
    idle(10);
    check("hs mid", g[HSD], 1'b0);
    hsv <= 8'hA0;
    await(HSD, 1'b1, 10, "hs on");
    hsv <= 8'h60;
    idle(10);
    check("hs hold", g[HSD], 1'b1);
    hsv <= 8'h20;
    await(HSD, 1'b0, 6, "hs off");
    check("hs gate off", g[HSG], 1'b0);
    hsv <= 8'hA0;
    idle(6);
  endtask
  task automatic s_start();
    check("no start low vin", g[BB], 1'b1);
    vin <= 12'h1F4;
    await(SRQ, 1'b1, 10, "start request");
    check("ls gate run", g[LSG], 1'b1);
    check("bang off run", g[BB], 1'b0);
    idle(1);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    await(BFS, 1'b1, 3, "burst start");
  endtask
  task automatic s_ocp();
    iset <= 8'hFF;
    idle(3);
    check("clamped", iset_clamped, 8'hE0);
    idle(27);
    check("no early restart", g[AR], 1'b0);
    await(AR, 1'b1, 20, "ocp1 restart");
    check("ls stop", g[LSG], 1'b0);
    check("hs stop", g[HSG], 1'b0);
    check("bang in prot", g[BB], 1'b1);
    iset <= 8'h40;
    apb(1'b0, `ADDR_STATUS, `ZERO32);
    check("ocp1 sticky", rd[2], 1'b1);
    await(SRQ, 1'b1, 200, "restart");
    check("sleep length", k >= 90, 1'b1);
  endtask
  task automatic s_drop();
    vin <= 12'h096;
    idle(20);
    check("slow blanked", g[BB], 1'b0);
    await(BB, 1'b1, 20, "slow dropout");
    vin <= 12'h1F4;
    await(SRQ, 1'b1, 10, "brown-in start");
    vin <= 12'h032;
    // Inside the slow blanking, so only the fast path can act
    await(BB, 1'b1, 27, "fast dropout");
    vin <= 12'h1F4;
    await(SRQ, 1'b1, 10, "start again");
  endtask
  task automatic s_ovp();
    vin <= 12'h3B6;
    await(AR, 1'b1, 27, "overvoltage");
    vin <= 12'h1F4;
    iset <= 8'h90;
    await(SRQ, 1'b1, 200, "ovp restart");
    idle(40);
    check("no early timeout", g[AR], 1'b0);
    await(AR, 1'b1, 60, "start timeout");
    check("timeout ls stop", g[LSG], 1'b0);
  endtask
  // Runs from the start-up timeout sleep: window expiry, then a long pulse
  task automatic s_window();
    apb(1'b1, `ADDR_WINDOW, 32'h0000_001E);
    vin <= 12'h0FA;
    iset <= 8'h40;
    idle(150);
    apb(1'b0, `ADDR_STATUS, `ZERO32);
    check("window sticky", rd[8], 1'b1);
    check("window state", rd[18:16], 3'h2);
    // One count of limit, so the three-cycle first pulse is too long
    apb(1'b1, `ADDR_PULSE_NUM, 32'h0000_01F4);
    vin <= 12'h1F4;
    await(SRQ, 1'b1, 20, "start after window");
    await(AR, 1'b1, 30, "long first pulse");
    apb(1'b0, `ADDR_STATUS, `ZERO32);
    check("shunt sticky", rd[3], 1'b1);
  endtask
  // Ceiling well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    idle(5);
    reset_n <= 1'b1;
    idle(2);
    s_regs();
    s_hs();
    s_start();
    s_ocp();
    s_drop();
    s_ovp();
    s_window();
    wrap_up();
  end
endmodule // protection_fault_supervisor_bench
